// ### verilog/adsp_map.svh
// constants for the speed-profile block: command codes, mode bit
// positions, reset values of the queued settings
// assumes the command decoder hands over whole 8-bit command codes
`ifndef ADSP_MAP_SVH
`define ADSP_MAP_SVH

// ----------------------------------------------------------------------
// command codes
// ----------------------------------------------------------------------
`define ADSP_CMD_PRE_CLEAR   8'h26
`define ADSP_CMD_PRE_SHIFT   8'h2b
`define ADSP_CMD_WR_PRE_HI   4'h8
`define ADSP_CMD_RD_PRE_HI   4'hc
`define ADSP_CMD_RD_WORK_HI  4'hd
`define ADSP_CMD_RD_COUNT    8'hf4
`define ADSP_CMD_RD_SPEED    8'hf5

// ----------------------------------------------------------------------
// register index in the low nibble of a register command
// ----------------------------------------------------------------------
`define ADSP_IDX_FEED        4'h0
`define ADSP_IDX_START       4'h1
`define ADSP_IDX_RUN         4'h2
`define ADSP_IDX_ACCEL       4'h3
`define ADSP_IDX_DECEL       4'h4
`define ADSP_IDX_MULT        4'h5
`define ADSP_IDX_RAMPDN      4'h6
`define ADSP_IDX_MODE        4'h7
`define ADSP_IDX_ACC_SRANGE  4'h9
`define ADSP_IDX_DEC_SRANGE  4'ha

// ----------------------------------------------------------------------
// operation mode bits
// ----------------------------------------------------------------------
`define ADSP_MODE_CURVE      0
`define ADSP_MODE_RAMP_MAN   1
`define ADSP_MODE_COMPOSITE  2
`define ADSP_MODE_TOPCORR    3

// ----------------------------------------------------------------------
// reset values and lower limits
// ----------------------------------------------------------------------
`define ADSP_RST_FEED        28'h0000000
`define ADSP_RST_START       16'h0001
`define ADSP_RST_RUN         16'h0001
`define ADSP_RST_ACCEL       16'h0001
`define ADSP_RST_DECEL       16'h0000
`define ADSP_RST_MULT        12'h002
`define ADSP_RST_RAMPDN      24'h000000
`define ADSP_RST_MODE        4'h0
`define ADSP_RST_SRANGE      15'h0000
`define ADSP_MIN_MULT        12'h002
`define ADSP_RATE_CLKS       2

`endif

// ### verilog/adsp_pkg.sv
// types shared by the speed-profile block
// assumes adsp_map.svh is on the include path
package adsp_pkg;

    typedef struct packed {
        logic [27:0] feed;
        logic [15:0] startSpd;
        logic [15:0] runSpd;
        logic [15:0] accelRate;
        logic [15:0] decelRate;
        logic [11:0] mult;
        logic [23:0] rampDown;
        logic [3:0]  mode;
        logic [14:0] accSRange;
        logic [14:0] decSRange;
    } adsp_prof_t;

    typedef enum logic [3:0] {
        ADSP_IDLE   = 4'b0001,
        ADSP_ACCEL  = 4'b0010,
        ADSP_CRUISE = 4'b0100,
        ADSP_DECEL  = 4'b1000
    } adsp_state_t;

    typedef enum logic [1:0] {
        ADSP_RUN_LOW  = 2'b00,
        ADSP_RUN_HIGH = 2'b01,
        ADSP_RUN_RAMP = 2'b10
    } adsp_start_t;

endpackage

// ### verilog/adsp_step_timer.sv
// rate interval timer: one tick every (rate + 1) * 4 reference clocks
// assumes rate is steady while enabled; clear restarts the interval
`timescale 1ns/10ps
`default_nettype none
`include "adsp_map.svh"

module adsp_step_timer
    import adsp_pkg::*;
#(
    parameter int RW = 16
) (
    input  wire logic          core_clk,
    input  wire logic          nrst,
    input  wire logic          enable,
    input  wire logic          clear,
    input  wire logic [RW-1:0] rate,
    output logic               tick
);
    logic [RW+1:0] count;
    logic [RW+1:0] next_count;
    logic [RW+1:0] lastCount;
    logic          next_tick;

    // (rate + 1) * 4 - 1 = rate * 4 + 3
    assign lastCount = {rate, 2'b11};

    always_comb begin
        next_count = count;
        next_tick  = 1'b0;
        if (clear || !enable) begin
            next_count = '0;
        end else if (count == lastCount) begin
            next_count = '0;
            next_tick  = 1'b1;
        end else begin
            next_count = count + 1'b1;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            count <= '0;
            tick  <= 1'b0;
        end else begin
            count <= next_count;
            tick  <= next_tick;
        end
    end
endmodule // adsp_step_timer
`default_nettype wire

// ### verilog/adsp_pulse_gen.sv
// pulse pacer: prescale by (mult + 1), then add speed into a 16-bit
// phase accumulator; each carry is one output pulse
// rate = speed * fclk / ((mult + 1) * 65536)
`timescale 1ns/10ps
`default_nettype none
`include "adsp_map.svh"

module adsp_pulse_gen
    import adsp_pkg::*;
#(
    parameter int SW = 16,
    parameter int MW = 12
) (
    input  wire logic          core_clk,
    input  wire logic          nrst,
    input  wire logic          enable,
    input  wire logic [SW-1:0] speed,
    input  wire logic [MW-1:0] mult,
    output logic               pulse
);
    logic [MW-1:0] pre;
    logic [MW-1:0] next_pre;
    logic [SW-1:0] phase;
    logic [SW-1:0] next_phase;
    logic          next_pulse;
    logic [SW:0]   sum;

    assign sum = {1'b0, phase} + {1'b0, speed};

    always_comb begin
        next_pre   = pre;
        next_phase = phase;
        next_pulse = 1'b0;
        if (!enable) begin
            next_pre   = '0;
            next_phase = '0;
        end else if (pre >= mult) begin
            next_pre   = '0;
            next_phase = sum[SW-1:0];
            next_pulse = sum[SW];
        end else begin
            next_pre = pre + 1'b1;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            pre   <= '0;
            phase <= '0;
            pulse <= 1'b0;
        end else begin
            pre   <= next_pre;
            phase <= next_phase;
            pulse <= next_pulse;
        end
    end
endmodule // adsp_pulse_gen
`default_nettype wire

// ### verilog/adsp_profile.sv
// per-axis speed-profile generator: queued and working settings,
// linear and S-curve ramps, ramp-down point, paced pulse output
// assumes commands and starts come from logic on core_clk
`timescale 1ns/10ps
`default_nettype none
`include "adsp_map.svh"

module adsp_profile
    import adsp_pkg::*;
(
    input  wire logic        core_clk,
    input  wire logic        nrst,
    input  wire logic        cmdValid,
    input  wire logic [7:0]  cmdCode,
    input  wire logic [31:0] cmdData,
    input  wire logic        startReq,
    input  wire adsp_start_t startKind,
    input  wire logic        stopReq,
    output logic [31:0]      readData,
    output logic             readValid,
    output logic             pulseOut,
    output logic             dirOut,
    output logic             busy,
    output logic             accelFlag,
    output logic             decelFlag,
    output logic             cruiseFlag,
    output logic [15:0]      speedMon,
    output logic [27:0]      remainMon
);
    // ------------------------------------------------------------------
    // settings: queued and working copies
    // ------------------------------------------------------------------
    adsp_prof_t pre, next_pre, work, next_work, rstProf;
    logic [31:0] next_readData;
    logic        next_readValid;
    logic [3:0]  idx;
    logic [3:0]  grp;
    logic        isWrite;

    assign idx     = cmdCode[3:0];
    assign grp     = cmdCode[7:4];
    assign isWrite = cmdValid && (grp == `ADSP_CMD_WR_PRE_HI);

    always_comb begin
        rstProf = '{feed: `ADSP_RST_FEED, startSpd: `ADSP_RST_START,
                    runSpd: `ADSP_RST_RUN, accelRate: `ADSP_RST_ACCEL,
                    decelRate: `ADSP_RST_DECEL, mult: `ADSP_RST_MULT,
                    rampDown: `ADSP_RST_RAMPDN, mode: `ADSP_RST_MODE,
                    accSRange: `ADSP_RST_SRANGE,
                    decSRange: `ADSP_RST_SRANGE};
    end

    function automatic logic [31:0] pick(adsp_prof_t p, logic [3:0] i);
        logic [31:0] r;
        r = '0;
        if (i == `ADSP_IDX_FEED) r = {{4{p.feed[27]}}, p.feed};
        else if (i == `ADSP_IDX_START) r = {16'h0000, p.startSpd};
        else if (i == `ADSP_IDX_RUN) r = {16'h0000, p.runSpd};
        else if (i == `ADSP_IDX_ACCEL) r = {16'h0000, p.accelRate};
        else if (i == `ADSP_IDX_DECEL) r = {16'h0000, p.decelRate};
        else if (i == `ADSP_IDX_MULT) r = {20'h00000, p.mult};
        else if (i == `ADSP_IDX_RAMPDN) r = {8'h00, p.rampDown};
        else if (i == `ADSP_IDX_MODE) r = {28'h0000000, p.mode};
        else if (i == `ADSP_IDX_ACC_SRANGE) r = {17'h00000, p.accSRange};
        else if (i == `ADSP_IDX_DEC_SRANGE) r = {17'h00000, p.decSRange};
        return r;
    endfunction

    always_comb begin
        next_pre       = pre;
        next_work      = work;
        next_readData  = readData;
        next_readValid = 1'b0;
        if (cmdValid && cmdCode == `ADSP_CMD_PRE_CLEAR) begin
            next_pre = rstProf;
        end else if (cmdValid && cmdCode == `ADSP_CMD_PRE_SHIFT) begin
            next_work = pre;
        end
        if (isWrite) begin
            if (idx == `ADSP_IDX_FEED) begin
                next_pre.feed = cmdData[27:0];
            end else if (idx == `ADSP_IDX_START) begin
                // zero is out of range; lowest legal speed kept
                next_pre.startSpd = (cmdData[15:0] == 16'h0000) ?
                                    16'h0001 : cmdData[15:0];
            end else if (idx == `ADSP_IDX_RUN) begin
                next_pre.runSpd = cmdData[15:0];
            end else if (idx == `ADSP_IDX_ACCEL) begin
                next_pre.accelRate = (cmdData[15:0] == 16'h0000) ?
                                     16'h0001 : cmdData[15:0];
            end else if (idx == `ADSP_IDX_DECEL) begin
                next_pre.decelRate = cmdData[15:0];
            end else if (idx == `ADSP_IDX_MULT) begin
                next_pre.mult = (cmdData[11:0] < `ADSP_MIN_MULT) ?
                                `ADSP_MIN_MULT : cmdData[11:0];
            end else if (idx == `ADSP_IDX_RAMPDN) begin
                next_pre.rampDown = cmdData[23:0];
            end else if (idx == `ADSP_IDX_MODE) begin
                next_pre.mode = cmdData[3:0];
            end else if (idx == `ADSP_IDX_ACC_SRANGE) begin
                next_pre.accSRange = cmdData[14:0];
            end else if (idx == `ADSP_IDX_DEC_SRANGE) begin
                next_pre.decSRange = cmdData[14:0];
            end
        end
        if (cmdValid && grp == `ADSP_CMD_RD_PRE_HI) begin
            next_readData  = pick(pre, idx);
            next_readValid = 1'b1;
        end else if (cmdValid && grp == `ADSP_CMD_RD_WORK_HI) begin
            next_readData  = pick(work, idx);
            next_readValid = 1'b1;
        end else if (cmdValid && cmdCode == `ADSP_CMD_RD_COUNT) begin
            next_readData  = {4'h0, remainMon};
            next_readValid = 1'b1;
        end else if (cmdValid && cmdCode == `ADSP_CMD_RD_SPEED) begin
            next_readData  = {16'h0000, speedMon};
            next_readValid = 1'b1;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            pre       <= rstProf;
            work      <= rstProf;
            readData  <= '0;
            readValid <= 1'b0;
        end else begin
            pre       <= next_pre;
            work      <= next_work;
            readData  <= next_readData;
            readValid <= next_readValid;
        end
    end

    // ------------------------------------------------------------------
    // derived ramp figures
    // ------------------------------------------------------------------
    logic [15:0] span;
    logic [15:0] decelEff;
    logic        curve;
    logic [15:0] accS;
    logic [15:0] decS;
    logic [16:0] accDen;
    logic [16:0] decDen;

    assign span     = work.runSpd - work.startSpd;
    assign decelEff = (work.decelRate == 16'h0000) ?
                      work.accelRate : work.decelRate;
    assign curve    = work.mode[`ADSP_MODE_CURVE];
    assign accS     = (work.accSRange == 15'h0000) ? {1'b0, span[15:1]}
                      : {1'b0, work.accSRange};
    assign decS     = (work.decSRange == 15'h0000) ? {1'b0, span[15:1]}
                      : {1'b0, work.decSRange};
    // a speed unit is gained (accel) or shed (decel) once the fraction reaches the denominator;
    // in S mode the slope ramps 0..2S over 2S intervals, covering S units
    assign accDen   = (curve && accS != 16'h0000) ? {accS, 1'b0} : 17'd1;
    assign decDen   = (curve && decS != 16'h0000) ? {decS, 1'b0} : 17'd1;

    // ------------------------------------------------------------------
    // profile state machine
    // ------------------------------------------------------------------
    adsp_state_t state, next_state;
    logic [15:0] speed, next_speed;
    logic [16:0] slope, next_slope;
    logic [16:0] frac, next_frac;
    logic [27:0] remain, next_remain;
    logic        dir, next_dir;
    logic [23:0] estimate, next_estimate;
    logic [16:0] estRem, next_estRem;
    logic        stepTick;
    logic        pulseTick;
    logic        timerClr;
    logic [16:0] den;
    logic [16:0] fsum;
    logic [16:0] urOne;
    logic [17:0] estSum;
    logic [24:0] autoPoint;
    logic        decelNow;
    logic        ramping;

    assign den     = (state == ADSP_DECEL) ? decDen : accDen;
    assign urOne   = {1'b0, work.accelRate} + 17'd1;
    assign ramping = (state == ADSP_ACCEL) || (state == ADSP_DECEL);
    assign timerClr = (state != next_state);

    // automatic point: pulses spent accelerating scaled by the rate
    // ratio, then moved by the signed offset; clamped at zero
    assign autoPoint = {1'b0, estimate}
                       + {{1{work.rampDown[23]}}, work.rampDown};

    always_comb begin
        if (work.mode[`ADSP_MODE_RAMP_MAN]) begin
            decelNow = ({4'h0, work.rampDown} >= remain);
        end else if (autoPoint[24] && !estimate[23]) begin
            decelNow = 1'b0;
        end else begin
            decelNow = ({4'h0, autoPoint[23:0]} >= remain);
        end
    end

    always_comb begin
        next_state    = state;
        next_speed    = speed;
        next_slope    = slope;
        next_frac     = frac;
        next_remain   = remain;
        next_dir      = dir;
        next_estimate = estimate;
        next_estRem   = estRem;
        fsum          = '0;
        estSum        = '0;
        case (state)
            ADSP_IDLE: begin
                if (startReq && work.feed != 28'h0000000) begin
                    next_dir    = work.feed[27];
                    next_remain = work.feed[27] ? (~work.feed + 28'd1)
                                                : work.feed;
                    next_slope    = curve ? 17'd0 : 17'd1;
                    next_frac     = '0;
                    next_estimate = '0;
                    next_estRem   = '0;
                    if (startKind == ADSP_RUN_HIGH) begin
                        next_speed = work.runSpd;
                        next_state = ADSP_CRUISE;
                    end else if (startKind == ADSP_RUN_RAMP) begin
                        next_speed = work.startSpd;
                        next_state = ADSP_ACCEL;
                    end else begin
                        next_speed = work.startSpd;
                        next_state = ADSP_DECEL;
                    end
                end
            end
            ADSP_ACCEL: begin
                if (stepTick) begin
                    if (!curve) begin
                        next_slope = 17'd1;
                    end else if ((work.runSpd - speed) <= accS) begin
                        if (slope > 17'd1) next_slope = slope - 17'd1;
                    end else if (slope < accDen) begin
                        next_slope = slope + 17'd1;
                    end
                    fsum = frac + next_slope;
                    if (fsum >= den) begin
                        next_frac = fsum - den;
                        if (speed < work.runSpd) next_speed = speed + 16'd1;
                    end else begin
                        next_frac = fsum;
                    end
                end
                if (pulseTick) begin
                    estSum = {1'b0, estRem} + {2'b00, decelEff} + 18'd1;
                    if (estSum >= {urOne, 1'b0}) begin
                        next_estRem   = 17'(estSum - {urOne, 1'b0});
                        next_estimate = estimate + 24'd2;
                    end else if (estSum >= {1'b0, urOne}) begin
                        next_estRem   = 17'(estSum - {1'b0, urOne});
                        next_estimate = estimate + 24'd1;
                    end else begin
                        next_estRem = estSum[16:0];
                    end
                end
                if (speed >= work.runSpd) begin
                    next_speed = work.runSpd;
                    next_state = ADSP_CRUISE;
                end
                if (decelNow) begin
                    next_state = ADSP_DECEL;
                    next_slope = curve ? 17'd0 : 17'd1;
                    next_frac  = '0;
                end
            end
            ADSP_CRUISE: begin
                if (decelNow && startKind != ADSP_RUN_HIGH) begin
                    next_state = ADSP_DECEL;
                    next_slope = curve ? 17'd0 : 17'd1;
                    next_frac  = '0;
                end
            end
            ADSP_DECEL: begin
                if (stepTick && speed > work.startSpd) begin
                    if (!curve) begin
                        next_slope = 17'd1;
                    end else if ((speed - work.startSpd) <= decS) begin
                        if (slope > 17'd1) next_slope = slope - 17'd1;
                    end else if (slope < decDen) begin
                        next_slope = slope + 17'd1;
                    end
                    fsum = frac + next_slope;
                    if (fsum >= den) begin
                        next_frac  = fsum - den;
                        next_speed = speed - 16'd1;
                    end else begin
                        next_frac = fsum;
                    end
                end
                // at start speed the axis keeps feeding until empty
                if (speed < work.startSpd) next_speed = work.startSpd;
            end
            default: next_state = ADSP_IDLE;
        endcase
        if (state != ADSP_IDLE && pulseTick) begin
            next_remain = remain - 28'd1;
            if (remain == 28'd1) next_state = ADSP_IDLE;
        end
        if (stopReq) next_state = ADSP_IDLE;
    end

    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            state    <= ADSP_IDLE;
            speed    <= '0;
            slope    <= '0;
            frac     <= '0;
            remain   <= '0;
            dir      <= 1'b0;
            estimate <= '0;
            estRem   <= '0;
        end else begin
            state    <= next_state;
            speed    <= next_speed;
            slope    <= next_slope;
            frac     <= next_frac;
            remain   <= next_remain;
            dir      <= next_dir;
            estimate <= next_estimate;
            estRem   <= next_estRem;
        end
    end

    // ------------------------------------------------------------------
    // timers and outputs
    // ------------------------------------------------------------------
    adsp_step_timer #(.RW(16)) u_step (
        .core_clk (core_clk),
        .nrst     (nrst),
        .enable   (ramping),
        .clear    (timerClr),
        .rate     ((state == ADSP_DECEL) ? decelEff : work.accelRate),
        .tick     (stepTick)
    );

    adsp_pulse_gen #(.SW(16), .MW(12)) u_pulse (
        .core_clk (core_clk),
        .nrst     (nrst),
        .enable   (state != ADSP_IDLE),
        .speed    (speed),
        .mult     (work.mult),
        .pulse    (pulseTick)
    );

    assign pulseOut   = pulseTick;
    assign dirOut     = dir;
    assign busy       = (state != ADSP_IDLE);
    assign accelFlag  = (state == ADSP_ACCEL);
    assign decelFlag  = (state == ADSP_DECEL);
    assign cruiseFlag = (state == ADSP_CRUISE);
    assign speedMon   = speed;
    assign remainMon  = remain;
endmodule // adsp_profile
`default_nettype wire

// ### verif/adsp_drv_model.sv
// pulse-string driver model: counts steps by direction, keeps last gap
// assumes pulses are one core_clk cycle wide
`timescale 1ns/10ps
`default_nettype none

module adsp_drv_model (
    input  wire logic core_clk,
    input  wire logic pulseIn,
    input  wire logic dirIn,
    output var  int   steps,
    output var  int   gap
);
    int cnt = 0;
    always @(posedge core_clk) begin
        cnt <= cnt + 1;
        if (pulseIn === 1'b1) begin
            steps <= dirIn ? steps - 1 : steps + 1;
            gap   <= cnt + 1;
            cnt   <= 0;
        end
    end
endmodule // adsp_drv_model
`default_nettype wire

// ### verif/adsp_profile_assertions.sv
// port-level checks of the speed-profile block
// assumes a single core_clk domain with synchronous nrst
`timescale 1ns/10ps
`default_nettype none

module adsp_profile_chk (
    input wire logic        core_clk,
    input wire logic        nrst,
    input wire logic        cmdValid,
    input wire logic [7:0]  cmdCode,
    input wire logic        stopReq,
    input wire logic        readValid,
    input wire logic        pulseOut,
    input wire logic        busy,
    input wire logic        accelFlag,
    input wire logic        decelFlag,
    input wire logic        cruiseFlag,
    input wire logic [15:0] speedMon,
    input wire logic [27:0] remainMon
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!nrst);
    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    chk_read_answer: assert property (
        cmdValid && cmdCode[7:5] == 3'b110 |=> readValid) else $error("no read");
    chk_pulse_space: assert property (
        pulseOut |=> !pulseOut) else $error("pulses back to back");
    chk_speed_step: assert property (
        busy && $past(busy) |-> 16'(speedMon - $past(speedMon) + 16'h1) <= 16'h2)
        else $error("speed jump");
    chk_remain_down: assert property (
        busy && $past(busy) |-> remainMon <= $past(remainMon)) else $error("remain up");
    chk_stop_idle: assert property (
        stopReq |=> !busy) else $error("stop ignored");
    chk_cruise_hold: assert property (
        cruiseFlag && $past(cruiseFlag) |-> $stable(speedMon)) else $error("cruise moved");
    chk_accel_rise: assert property (
        accelFlag && $past(accelFlag) |-> speedMon >= $past(speedMon)) else $error("accel fell");
    chk_decel_fall: assert property (
        decelFlag && $past(decelFlag) |-> speedMon <= $past(speedMon)) else $error("decel rose");
    chk_phase_one: assert property (
        busy |-> $onehot({accelFlag, decelFlag, cruiseFlag})) else $error("phase flags");
    cov_accel: cover property (accelFlag ##1 cruiseFlag);
    cov_decel: cover property (decelFlag ##1 !busy);
    cov_stop: cover property (stopReq && busy);
endmodule // adsp_profile_chk

bind adsp_profile adsp_profile_chk u_chk (
    .core_clk   (core_clk),
    .nrst       (nrst),
    .cmdValid   (cmdValid),
    .cmdCode    (cmdCode),
    .stopReq    (stopReq),
    .readValid  (readValid),
    .pulseOut   (pulseOut),
    .busy       (busy),
    .accelFlag  (accelFlag),
    .decelFlag  (decelFlag),
    .cruiseFlag (cruiseFlag),
    .speedMon   (speedMon),
    .remainMon  (remainMon)
);
`default_nettype wire

// ### verif/adsp_profile_test.sv
// testbench: command-port register tests and timed ramped moves
// assumes adsp_map.svh on the include path
`timescale 1ns/10ps
`default_nettype none

module adsp_profile_test;
    import adsp_pkg::*;
    logic core_clk = 0, nrst = 0, cmdValid = 0, startReq = 0, stopReq = 0;
    logic [7:0] cmdCode = 8'h00;
    logic [31:0] cmdData = 32'h0, readData;
    adsp_start_t startKind = ADSP_RUN_LOW;
    logic readValid, pulseOut, dirOut, busy, accelFlag, decelFlag, cruiseFlag;
    logic [15:0] speedMon;
    logic [27:0] remainMon;
    int num_errors = 0, n_tests = 0, steps, gap;
    int tbl [4][3] = '{'{2, 0, 80}, '{3, 0, 160}, '{3, 2, 112}, '{0, 0, 80}};
    logic [31:0] rv [5] = '{1, 1, 1, 0, 2};

    adsp_profile dut (
        .core_clk(core_clk), .nrst(nrst), .cmdValid(cmdValid),
        .cmdCode(cmdCode), .cmdData(cmdData), .startReq(startReq),
        .startKind(startKind), .stopReq(stopReq), .readData(readData),
        .readValid(readValid), .pulseOut(pulseOut), .dirOut(dirOut),
        .busy(busy), .accelFlag(accelFlag), .decelFlag(decelFlag),
        .cruiseFlag(cruiseFlag), .speedMon(speedMon),
        .remainMon(remainMon));
    adsp_drv_model drv (.core_clk(core_clk), .pulseIn(pulseOut),
                        .dirIn(dirOut), .steps(steps), .gap(gap));
    initial forever #25 core_clk = ~core_clk;

    task automatic end_sim;
        $display("tests %0d errors %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic cmd(input logic [7:0] c, input logic [31:0] d);
        @(posedge core_clk); #1;
        {cmdValid, cmdCode, cmdData} = {1'b1, c, d};
        @(posedge core_clk); #1;
        cmdValid = 0;
    endtask
    task automatic rd(input logic [7:0] c, input logic [31:0] exp);
        cmd(c, 0);
        chk(32'(readValid), 1);
        chk(readData, exp);
    endtask
    // ----------------------------------------------------------------
    // one move: count accel cycles, check decel point and step total
    // ----------------------------------------------------------------
    task automatic move(input adsp_start_t k, input int n, acc, tol, man);
        int na = 0, lim = 0, s0 = steps;
        logic first = 1;
        @(posedge core_clk); #1;
        {startReq, startKind} = {1'b1, k};
        @(posedge core_clk); #1;
        startReq = 0;
        while (busy === 1'b1 && lim < 20000) begin
            if (accelFlag === 1'b1) na++;
            if (decelFlag === 1'b1 && first && man) chk(32'(remainMon <= 5), 1);
            if (decelFlag === 1'b1) first = 0;
            @(posedge core_clk); #1;
            lim++;
        end
        chk(32'(na >= acc - tol && na <= acc + tol), 1);
        chk(steps - s0, n);
        chk(32'(lim < 20000), 1);
        // start speed 1000, mult 2: 65 or 66 phase adds of 3 clocks
        chk(32'(gap == 195 || gap == 198), 1);
    endtask

    initial begin
        repeat (10) @(posedge core_clk);
        #1 nrst = 1;
        for (int i = 0; i < 5; i++) rd(8'(8'hd1 + i), rv[i]);
        cmd(8'h81, 0);
        rd(8'hc1, 1);
        cmd(8'h85, 1);
        rd(8'hc5, 2);
        cmd(8'h80, 32'h0fffffff);
        rd(8'hc0, 32'hffffffff);
        cmd(8'h82, 100);
        cmd(8'h8a, 3);
        rd(8'hca, 3);
        cmd(8'h26, 0);
        rd(8'hc2, 1);
        rd(8'hca, 0);
        cmd(8'h81, 1000);
        cmd(8'h82, 1010);
        cmd(8'h83, 1);
        cmd(8'h84, 0);
        cmd(8'h85, 2);
        cmd(8'h80, 20);
        cmd(8'h86, 5);
        foreach (tbl[i]) begin
            cmd(8'h87, tbl[i][0]);
            cmd(8'h89, tbl[i][1]);
            cmd(8'h2b, 0);
            rd(8'hd2, 1010);
            move(ADSP_RUN_RAMP, 20, tbl[i][2], tbl[i][0] ? 24 : 4, tbl[i][0] > 1);
        end
        cmd(8'h80, 32'h0ffffffd);
        cmd(8'h2b, 0);
        move(ADSP_RUN_LOW, -3, 0, 0, 0);
        @(posedge core_clk); #1;
        {startReq, startKind} = {1'b1, ADSP_RUN_HIGH};
        @(posedge core_clk); #1;
        startReq = 0;
        repeat (50) @(posedge core_clk);
        #1 stopReq = 1;
        @(posedge core_clk); #1;
        stopReq = 0;
        chk(32'(busy), 0);
        rd(8'hf5, 1010);
        rd(8'hf4, 3);
        end_sim;
    end
    initial begin
        repeat (60000) @(posedge core_clk);
        num_errors++;
        end_sim;
    end
endmodule // adsp_profile_test
`default_nettype wire
